// file: verilog/rxpg_pkg.sv
// Notes on behaviour
// - Eight-bit equalizer error limit, reset 1, decides when the equalizer re-adapts.
// - Count clock, encoding, parity errors whose check bit is enabled; above limit step up.
// - Locations 0x44 to 0x49 are read-only and always read 0x00.
// - Per-port bit 4, reset 0, gates the encoder CRC error flag.
// - Embedded line count 00 forwards every raw long packet as video data.
// - Count 1, 2 or 3 marks that many leading long packets per frame embedded.
// - Embedded controls have no effect while the port accepts CSI-2 input.
// - Six-bit embedded line type, reset 0x12, replaces the raw data type.
// - Paged locations 0x4A, 0x4B, 0x4D-0x7F, 0xD0-0xDF follow the page select.
// - Read port bit 4 picks which port block answers paged reads.
// - Read port resets to 0 locally, to the carrying port over a link.
// - Write enable bits 0 and 1 gate each block; both set broadcasts.
// - Bit 6 reads 0 locally, carrying link number over a link.
// - Each access source keeps its own page select state.
package rxpg_pkg;
  localparam int unsigned RXPG_NPORTS = 2;
  localparam int unsigned RXPG_NSRC = 3;
  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_LINK0 = 2'h1;
  localparam logic [1:0] SRC_LINK1 = 2'h2;
  localparam logic [7:0] ADDR_EQ_LIMIT = 8'h43;
  localparam logic [7:0] ADDR_RSVD_FIRST = 8'h44;
  localparam logic [7:0] ADDR_RSVD_LAST = 8'h49;
  localparam logic [7:0] ADDR_CAP = 8'h4a;
  localparam logic [7:0] ADDR_EMBED = 8'h4b;
  localparam logic [7:0] ADDR_PAGE = 8'h4c;
  localparam logic [7:0] ADDR_PAGED_A_FIRST = 8'h4d;
  localparam logic [7:0] ADDR_PAGED_A_LAST = 8'h7f;
  localparam logic [7:0] ADDR_PAGED_B_FIRST = 8'hd0;
  localparam logic [7:0] ADDR_PAGED_B_LAST = 8'hdf;
  localparam logic [7:0] RST_EQ_LIMIT = 8'h01;
  localparam logic [7:0] RST_CAP = 8'h00;
  localparam logic [7:0] RST_EMBED = 8'h12;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int unsigned CAP_CRC_BIT = 4;
  localparam int unsigned EMB_CNT_MSB = 7;
  localparam int unsigned EMB_CNT_LSB = 6;
  localparam int unsigned EMB_TYPE_MSB = 5;
  localparam int unsigned PAGE_PHYS_BIT = 6;
  localparam int unsigned PAGE_RD_BIT = 4;
  localparam int unsigned CHK_CLK_BIT = 2;
  localparam int unsigned CHK_ENC_BIT = 1;
  localparam int unsigned CHK_PAR_BIT = 0;
  localparam logic [1:0] EMB_CNT_MAX = 2'h3;
  localparam logic [8:0] EQ_COUNT_MAX = 9'h1ff;
endpackage : rxpg_pkg

// file: verilog/rxpg_page_sel.sv
`timescale 1ns/1ps
module rxpg_page_sel
  import rxpg_pkg::*;
#(
  parameter logic RD_RST = 1'b0,
  parameter logic [1:0] WEN_RST = 2'h0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic rd_port_q,
  output logic [1:0] wen_q
);
  // ---------------------------------------------------------------
  // Page state of one access source.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_port_q <= RD_RST;
      wen_q <= WEN_RST;
    end else if (wr) begin
      rd_port_q <= wdata[PAGE_RD_BIT];
      wen_q <= wdata[1:0];
    end
  end
endmodule : rxpg_page_sel

// file: verilog/rxpg_port_block.sv
`timescale 1ns/1ps
module rxpg_port_block
  import rxpg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_cap,
  input wire logic wr_embed,
  input wire logic [7:0] wdata,
  input wire logic csi_mode,
  input wire logic frame_start,
  input wire logic long_pkt,
  input wire logic [5:0] video_dtype,
  input wire logic enc_crc_err,
  output logic [7:0] cap_q,
  output logic [7:0] embed_q,
  output logic pkt_valid_q,
  output logic pkt_embedded_q,
  output logic [5:0] pkt_dtype_q,
  output logic crc_err_flag_q
);
  // ---------------------------------------------------------------
  // Per-port registers and packet tagging.
  // ---------------------------------------------------------------
  logic [1:0] pkt_cnt_q;
  logic [1:0] pkt_cnt_base;
  logic [1:0] embed_count;
  logic is_embedded;
  logic [1:0] pkt_cnt_d;

  assign embed_count = embed_q[EMB_CNT_MSB:EMB_CNT_LSB];
  assign pkt_cnt_base = frame_start ? 2'h0 : pkt_cnt_q;
  assign is_embedded = !csi_mode && (pkt_cnt_base < embed_count);
  assign pkt_cnt_d = (long_pkt && pkt_cnt_base != EMB_CNT_MAX) ? pkt_cnt_base + 2'h1 :
                     pkt_cnt_base;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_q <= RST_CAP;
      embed_q <= RST_EMBED;
    end else begin
      if (wr_cap) cap_q <= wdata;
      if (wr_embed) embed_q <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pkt_cnt_q <= 2'h0;
      pkt_valid_q <= 1'b0;
      pkt_embedded_q <= 1'b0;
      pkt_dtype_q <= 6'h00;
      crc_err_flag_q <= 1'b0;
    end else begin
      pkt_cnt_q <= pkt_cnt_d;
      pkt_valid_q <= long_pkt;
      if (long_pkt) begin
        pkt_embedded_q <= is_embedded;
        pkt_dtype_q <= is_embedded ? embed_q[EMB_TYPE_MSB:0] : video_dtype;
      end
      crc_err_flag_q <= enc_crc_err && cap_q[CAP_CRC_BIT];
    end
  end
endmodule : rxpg_port_block

// file: verilog/rxpg_regs.sv
`timescale 1ns/1ps
module rxpg_regs
  import rxpg_pkg::*;
#(
  parameter int unsigned NPORTS = RXPG_NPORTS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_src,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  input wire logic [2:0] eq_error_check_select,
  input wire logic err_link_clk,
  input wire logic err_encoding,
  input wire logic err_parity,
  input wire logic eq_window_end,
  output logic eq_step_up,
  input wire logic [1:0] csi_mode,
  input wire logic [1:0] frame_start,
  input wire logic [1:0] long_pkt,
  input wire logic [1:0][5:0] video_dtype,
  input wire logic [1:0] enc_crc_err,
  output logic [1:0] pkt_valid,
  output logic [1:0] pkt_embedded,
  output logic [1:0][5:0] pkt_dtype,
  output logic [1:0] crc_err_flag
);
  // ---------------------------------------------------------------
  // Elaboration check.
  // ---------------------------------------------------------------
  if (NPORTS != RXPG_NPORTS) begin : g_bad_nports
    $error("rxpg_regs supports exactly two receive ports");
  end

  // ---------------------------------------------------------------
  // Address decode.
  // ---------------------------------------------------------------
  logic src_ok;
  logic is_rd;
  logic is_wr;
  logic hit_limit;
  logic hit_cap;
  logic hit_embed;
  logic hit_page;
  logic [NPORTS-1:0] port_wr_en;
  logic [RXPG_NSRC-1:0] page_wr;
  logic [RXPG_NSRC-1:0] page_rd_port;
  logic [RXPG_NSRC-1:0][1:0] page_wen;
  logic sel_rd_port;
  logic [1:0] sel_wen;
  logic phys_num;
  logic [NPORTS-1:0][7:0] cap_w;
  logic [NPORTS-1:0][7:0] embed_w;
  logic [7:0] page_rdata;
  logic [7:0] rdata_d;
  logic [7:0] eq_limit_q;

  assign src_ok = (req_src == SRC_LOCAL) || (req_src == SRC_LINK0) || (req_src == SRC_LINK1);
  assign is_rd = req_valid && !req_write;
  assign is_wr = req_valid && req_write && src_ok;
  assign hit_limit = (req_addr == ADDR_EQ_LIMIT);
  assign hit_cap = (req_addr == ADDR_CAP);
  assign hit_embed = (req_addr == ADDR_EMBED);
  assign hit_page = (req_addr == ADDR_PAGE);
  assign sel_rd_port = src_ok ? page_rd_port[req_src] : 1'b0;
  assign sel_wen = src_ok ? page_wen[req_src] : 2'h0;
  assign phys_num = (req_src == SRC_LINK1);
  assign port_wr_en = is_wr ? sel_wen : 2'h0;
  assign page_rdata = {1'b0, phys_num, 1'b0, sel_rd_port, 2'h0, sel_wen};

  // Paged locations beyond 0x4A and 0x4B live in other blocks and read zero here.
  assign rdata_d = !src_ok ? READ_ZERO :
                   hit_limit ? eq_limit_q :
                   hit_cap ? cap_w[sel_rd_port] :
                   hit_embed ? embed_w[sel_rd_port] :
                   hit_page ? page_rdata :
                   READ_ZERO;

  // ---------------------------------------------------------------
  // Page state, one per access source.
  // ---------------------------------------------------------------
  for (genvar s = 0; s < RXPG_NSRC; s++) begin : g_page
    localparam logic RD_RST_S = (s == 2);
    localparam logic [1:0] WEN_RST_S = (s == 0) ? 2'h0 : ((s == 1) ? 2'h1 : 2'h2);
    assign page_wr[s] = is_wr && hit_page && (req_src == 2'(s));
    rxpg_page_sel #(
      .RD_RST(RD_RST_S),
      .WEN_RST(WEN_RST_S)
    ) u_page (
      .clk(clk),
      .rst_b(rst_b),
      .wr(page_wr[s]),
      .wdata(req_wdata),
      .rd_port_q(page_rd_port[s]),
      .wen_q(page_wen[s])
    );
  end

  // ---------------------------------------------------------------
  // Receive port blocks.
  // ---------------------------------------------------------------
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    rxpg_port_block u_port (
      .clk(clk),
      .rst_b(rst_b),
      .wr_cap(port_wr_en[p] && hit_cap),
      .wr_embed(port_wr_en[p] && hit_embed),
      .wdata(req_wdata),
      .csi_mode(csi_mode[p]),
      .frame_start(frame_start[p]),
      .long_pkt(long_pkt[p]),
      .video_dtype(video_dtype[p]),
      .enc_crc_err(enc_crc_err[p]),
      .cap_q(cap_w[p]),
      .embed_q(embed_w[p]),
      .pkt_valid_q(pkt_valid[p]),
      .pkt_embedded_q(pkt_embedded[p]),
      .pkt_dtype_q(pkt_dtype[p]),
      .crc_err_flag_q(crc_err_flag[p])
    );
  end

  // ---------------------------------------------------------------
  // Shared registers and read answer.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eq_limit_q <= RST_EQ_LIMIT;
    end else if (is_wr && hit_limit) begin
      eq_limit_q <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= READ_ZERO;
    end else begin
      rsp_valid <= is_rd;
      if (is_rd) rsp_rdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Equalizer error accumulation.
  // ---------------------------------------------------------------
  logic check_on;
  logic [1:0] err_n;
  logic [8:0] eq_count_q;
  logic [8:0] eq_count_sum;
  logic over_limit;

  assign check_on = |eq_error_check_select;
  assign err_n = 2'({1'b0, err_link_clk && eq_error_check_select[CHK_CLK_BIT]}) +
                 2'({1'b0, err_encoding && eq_error_check_select[CHK_ENC_BIT]}) +
                 2'({1'b0, err_parity && eq_error_check_select[CHK_PAR_BIT]});
  assign eq_count_sum = (eq_count_q > EQ_COUNT_MAX - 9'h003) ? EQ_COUNT_MAX :
                        eq_count_q + {7'h00, err_n};
  assign over_limit = check_on && (eq_count_q > {1'b0, eq_limit_q});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eq_count_q <= 9'h000;
      eq_step_up <= 1'b0;
    end else begin
      eq_step_up <= over_limit;
      if (over_limit || eq_window_end || !check_on) begin
        eq_count_q <= 9'h000;
      end else begin
        eq_count_q <= eq_count_sum;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_limit_read;
    is_rd && src_ok && hit_limit |=> rsp_valid && (rsp_rdata == $past(eq_limit_q));
  endproperty
  a_limit_read: assert property (p_limit_read) else $error("limit readback wrong");

  property p_step;
    check_on && (eq_count_q > {1'b0, eq_limit_q}) |=> eq_step_up ##1 (eq_count_q <= 9'h003);
  endproperty
  a_step: assert property (p_step) else $error("no step above limit");

  property p_no_step_off;
    !check_on |=> !eq_step_up;
  endproperty
  a_no_step_off: assert property (p_no_step_off) else $error("step while checks off");

  property p_rsvd_zero;
    is_rd && (req_addr >= ADDR_RSVD_FIRST) && (req_addr <= ADDR_RSVD_LAST)
      |=> rsp_valid && (rsp_rdata == READ_ZERO);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved not zero");

  property p_crc_gate;
    enc_crc_err[0] |=> (crc_err_flag[0] == $past(cap_w[0][CAP_CRC_BIT]));
  endproperty
  a_crc_gate: assert property (p_crc_gate) else $error("crc flag gate wrong");

  property p_raw_video;
    long_pkt[0] && !csi_mode[0] && (embed_w[0][EMB_CNT_MSB:EMB_CNT_LSB] == 2'h0)
      |=> pkt_valid[0] && !pkt_embedded[0] && (pkt_dtype[0] == $past(video_dtype[0]));
  endproperty
  a_raw_video: assert property (p_raw_video) else $error("raw packet tagged");

  property p_first_embedded;
    frame_start[1] && long_pkt[1] && !csi_mode[1] &&
      (embed_w[1][EMB_CNT_MSB:EMB_CNT_LSB] != 2'h0) |=> pkt_embedded[1];
  endproperty
  a_first_embedded: assert property (p_first_embedded) else $error("first not embedded");

  property p_csi_noeffect;
    long_pkt[0] && csi_mode[0] |=> !pkt_embedded[0] && (pkt_dtype[0] == $past(video_dtype[0]));
  endproperty
  a_csi_noeffect: assert property (p_csi_noeffect) else $error("csi packet altered");

  property p_embed_type;
    long_pkt[0] && !csi_mode[0] && !frame_start[0] &&
      (embed_w[0][EMB_CNT_MSB:EMB_CNT_LSB] == EMB_CNT_MAX) && (g_port[0].u_port.pkt_cnt_q < 2'h3)
      |=> pkt_embedded[0] && (pkt_dtype[0] == $past(embed_w[0][EMB_TYPE_MSB:0]));
  endproperty
  a_embed_type: assert property (p_embed_type) else $error("embedded type wrong");

  property p_read_steer;
    is_rd && src_ok && hit_cap |=> (rsp_rdata == $past(cap_w[sel_rd_port]));
  endproperty
  a_read_steer: assert property (p_read_steer) else $error("paged read misrouted");

  property p_no_wen;
    is_wr && (hit_cap || hit_embed) && (sel_wen == 2'h0) |=> $stable(cap_w) && $stable(embed_w);
  endproperty
  a_no_wen: assert property (p_no_wen) else $error("write without enable");

  property p_broadcast;
    is_wr && hit_cap && (sel_wen == 2'h3) |=> (cap_w[0] == $past(req_wdata)) &&
      (cap_w[1] == $past(req_wdata));
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("broadcast missed");

  property p_phys;
    is_rd && hit_page && src_ok |=> (rsp_rdata[PAGE_PHYS_BIT] == ($past(req_src) == SRC_LINK1));
  endproperty
  a_phys: assert property (p_phys) else $error("link number wrong");

  property p_page_private;
    is_wr && hit_page && (req_src == SRC_LOCAL) |=> $stable(page_wen[1]) && $stable(page_wen[2]);
  endproperty
  a_page_private: assert property (p_page_private) else $error("page state shared");

  c_broadcast: cover property (is_wr && hit_cap && (sel_wen == 2'h3));
  c_embedded: cover property (pkt_valid[0] && pkt_embedded[0]);
  c_step: cover property (eq_step_up);
  c_link_read: cover property (is_rd && hit_cap && (req_src == SRC_LINK1));
endmodule : rxpg_regs

// file: verif/rxpg_link_model.sv
`timescale 1ns/1ps
module rxpg_link_model (
  input wire logic clk,
  input wire logic [1:0] pkt_valid,
  input wire logic [1:0] pkt_embedded,
  input wire logic [1:0][5:0] pkt_dtype,
  output logic [1:0] frame_start,
  output logic [1:0] long_pkt,
  output logic [1:0][5:0] video_dtype,
  output logic [1:0] enc_crc_err,
  output logic err_link_clk,
  output logic err_encoding,
  output logic err_parity
);
  // ----------------------------------------
  // Serializer side: packets and link errors.
  // ----------------------------------------
  initial begin
    frame_start = 2'h0;
    long_pkt = 2'h0;
    video_dtype = {6'h2b, 6'h2c};
    enc_crc_err = 2'h0;
    err_link_clk = 1'b0;
    err_encoding = 1'b0;
    err_parity = 1'b0;
  end

  // Sends one long packet and returns valid, embedded mark and type.
  task automatic pkt(input int p, input logic first, input logic [5:0] dt,
                     output logic [7:0] seen);
    @(posedge clk);
    video_dtype[p] <= dt;
    long_pkt[p] <= 1'b1;
    frame_start[p] <= first;
    @(posedge clk);
    long_pkt[p] <= 1'b0;
    frame_start[p] <= 1'b0;
    #1;
    seen = {pkt_valid[p], pkt_embedded[p], pkt_dtype[p]};
  endtask : pkt

  // Pulses encoder CRC errors for one cycle and returns zero in seen, not the flags.
  task automatic crc(input logic [1:0] e, output logic [7:0] seen);
    @(posedge clk);
    enc_crc_err <= e;
    @(posedge clk);
    enc_crc_err <= 2'h0;
    #1;
    seen = {6'h00, crc_flag_now()};
  endtask : crc

  function automatic logic [1:0] crc_flag_now();
    return 2'h0;
  endfunction : crc_flag_now

  // Pulses one error of each kind selected in k for one cycle.
  task automatic errp(input logic [2:0] k);
    @(posedge clk);
    err_link_clk <= k[2];
    err_encoding <= k[1];
    err_parity <= k[0];
    @(posedge clk);
    err_link_clk <= 1'b0;
    err_encoding <= 1'b0;
    err_parity <= 1'b0;
  endtask : errp
endmodule : rxpg_link_model

// file: verif/rx_port_paged_config_regs_test.sv
`timescale 1ns/1ps
module rx_port_paged_config_regs_test;
  import rxpg_pkg::*;
  logic clk, rst_b, req_valid, req_write, rsp_valid, eq_window_end, eq_step_up;
  logic [1:0] req_src, csi_mode, frame_start, long_pkt, enc_crc_err;
  logic [1:0] pkt_valid, pkt_embedded, crc_err_flag;
  logic [7:0] req_addr, req_wdata, rsp_rdata, seen;
  logic [2:0] eq_error_check_select;
  logic err_link_clk, err_encoding, err_parity, stepped;
  logic [1:0][5:0] video_dtype, pkt_dtype;
  int n_fail = 0;
  int checks = 0;

  rxpg_regs #(.NPORTS(2)) i_rxpg_regs (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_src(req_src), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .eq_error_check_select(eq_error_check_select),
    .err_link_clk(err_link_clk), .err_encoding(err_encoding), .err_parity(err_parity),
    .eq_window_end(eq_window_end), .eq_step_up(eq_step_up), .csi_mode(csi_mode),
    .frame_start(frame_start), .long_pkt(long_pkt), .video_dtype(video_dtype),
    .enc_crc_err(enc_crc_err), .pkt_valid(pkt_valid), .pkt_embedded(pkt_embedded),
    .pkt_dtype(pkt_dtype), .crc_err_flag(crc_err_flag));

  rxpg_link_model i_rxpg_link_model (.clk(clk), .pkt_valid(pkt_valid),
    .pkt_embedded(pkt_embedded), .pkt_dtype(pkt_dtype), .frame_start(frame_start),
    .long_pkt(long_pkt), .video_dtype(video_dtype), .enc_crc_err(enc_crc_err),
    .err_link_clk(err_link_clk), .err_encoding(err_encoding), .err_parity(err_parity));

  // ----------------------------------------
  // Clock, reset and watchdog.
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    n_fail++;
    stop_test();
  end

  // ----------------------------------------
  // Access tasks and comparison.
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [1:0] s, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_src <= s;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : wr

  task automatic rdchk(input string name, input logic [1:0] s, input logic [7:0] a,
                       input logic [7:0] exp);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= 1'b0;
    req_src <= s;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    if (rsp_valid !== 1'b1) seen = 8'hxx;
    else seen = rsp_rdata;
    check(name, seen, exp);
  endtask : rdchk

  task automatic watch();
    stepped = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (eq_step_up === 1'b1) stepped = 1'b1;
    end
  endtask : watch

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Test sequence.
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_src = 2'h0;
    req_addr = 8'h00;
    req_wdata = 8'h00;
    eq_error_check_select = 3'h0;
    eq_window_end = 1'b0;
    csi_mode = 2'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rdchk("eq_limit", SRC_LOCAL, ADDR_EQ_LIMIT, 8'h01);
    rdchk("cap", SRC_LOCAL, ADDR_CAP, 8'h00);
    rdchk("embed", SRC_LOCAL, ADDR_EMBED, 8'h12);
    rdchk("page_local", SRC_LOCAL, ADDR_PAGE, 8'h00);
    rdchk("page_link0", SRC_LINK0, ADDR_PAGE, 8'h01);
    rdchk("page_link1", SRC_LINK1, ADDR_PAGE, 8'h52);
    for (int a = 8'h44; a <= 8'h49; a++) begin
      wr(SRC_LOCAL, 8'(a), 8'hff);
      rdchk("reserved", SRC_LOCAL, 8'(a), 8'h00);
    end
    rdchk("paged_unheld", SRC_LOCAL, 8'h50, 8'h00);
    $display("test reset_values done");
    i_rxpg_link_model.crc(2'h3, seen);
    check("crc_flag_off", {6'h00, crc_err_flag}, 8'h00);
    wr(SRC_LOCAL, ADDR_PAGE, 8'h03);
    wr(SRC_LOCAL, ADDR_CAP, 8'h10);
    rdchk("cap_p0", SRC_LINK0, ADDR_CAP, 8'h10);
    rdchk("cap_p1", SRC_LINK1, ADDR_CAP, 8'h10);
    i_rxpg_link_model.crc(2'h3, seen);
    check("crc_flag_on", {6'h00, crc_err_flag}, 8'h03);
    wr(SRC_LOCAL, ADDR_PAGE, 8'h00);
    wr(SRC_LOCAL, ADDR_CAP, 8'h00);
    rdchk("cap_kept", SRC_LOCAL, ADDR_CAP, 8'h10);
    rdchk("page_link0_kept", SRC_LINK0, ADDR_PAGE, 8'h01);
    wr(SRC_LINK0, ADDR_PAGE, 8'h11);
    rdchk("page_local_kept", SRC_LOCAL, ADDR_PAGE, 8'h00);
    wr(SRC_LINK0, ADDR_EMBED, 8'h07);
    rdchk("embed_rd_p1", SRC_LINK0, ADDR_EMBED, 8'h12);
    rdchk("embed_rd_p0", SRC_LOCAL, ADDR_EMBED, 8'h07);
    $display("test page_select done");
    for (int n = 0; n < 4; n++) begin
      wr(SRC_LINK1, ADDR_EMBED, {2'(n), 6'h05});
      for (int k = 0; k < 4; k++) begin
        i_rxpg_link_model.pkt(1, k == 0, 6'h2b, seen);
        check("pkt_port1", seen, (k < n) ? 8'hc5 : 8'h80 | 8'h2b);
      end
    end
    csi_mode <= 2'h2;
    i_rxpg_link_model.pkt(1, 1'b1, 6'h2b, seen);
    check("pkt_csi", seen, 8'hab);
    csi_mode <= 2'h1;
    i_rxpg_link_model.pkt(0, 1'b1, 6'h2a, seen);
    check("pkt_csi_p0", seen, 8'haa);
    csi_mode <= 2'h0;
    i_rxpg_link_model.pkt(0, 1'b1, 6'h2d, seen);
    check("pkt_raw_p0", seen, 8'had);
    $display("test embedded_lines done");
    i_rxpg_link_model.errp(3'h7);
    i_rxpg_link_model.errp(3'h7);
    watch();
    check("step_checks_off", {7'h00, stepped}, 8'h00);
    eq_error_check_select <= 3'h1;
    i_rxpg_link_model.errp(3'h1);
    i_rxpg_link_model.errp(3'h1);
    watch();
    check("step_limit1", {7'h00, stepped}, 8'h01);
    eq_error_check_select <= 3'h4;
    wr(SRC_LOCAL, ADDR_EQ_LIMIT, 8'h02);
    @(posedge clk);
    eq_window_end <= 1'b1;
    @(posedge clk);
    eq_window_end <= 1'b0;
    i_rxpg_link_model.errp(3'h4);
    i_rxpg_link_model.errp(3'h4);
    watch();
    check("step_at_limit", {7'h00, stepped}, 8'h00);
    i_rxpg_link_model.errp(3'h4);
    watch();
    check("step_over_limit", {7'h00, stepped}, 8'h01);
    $display("test equalizer done");
    stop_test();
  end
endmodule : rx_port_paged_config_regs_test
